// >>> core/omd_pkg.sv
// Constants and types shared by the operating-mode decoder.
// Assumes a single system clock and an AXI4-Lite register port.
`default_nettype none

package omd_pkg;

   // ------------------------------------------------------------
   // Bus
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] MON_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] CTRL_OFFSET = 8'h08;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int unsigned CTRL_EXT_BIT = 0;
   localparam int unsigned CTRL_AREA_LSB = 8;
   localparam int unsigned AREA_COUNT = 8;

   // ------------------------------------------------------------
   // Status register fields
   // ------------------------------------------------------------
   localparam int unsigned ST_MODE_LSB = 0;
   localparam int unsigned ST_VALID_BIT = 4;
   localparam int unsigned ST_ROM_BIT = 5;
   localparam int unsigned ST_EXT_BIT = 6;
   localparam int unsigned ST_BUS16_BIT = 7;
   localparam int unsigned ST_BOOT_BIT = 8;
   localparam int unsigned ST_USER_BIT = 9;
   localparam int unsigned ST_FLASH_BIT = 10;
   localparam int unsigned ST_CAPT_BIT = 11;

   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [2:0] MON_RESET = 3'h0;
   localparam logic [7:0] AREA_ALL_16 = 8'hFF;
   localparam logic [7:0] AREA_ALL_8 = 8'h00;
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [1:0] CAPTURE_DELAY = 2'h3;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      OMD_BUILD_FLASH,
      OMD_BUILD_MASKED,
      OMD_BUILD_ROMLESS
   } omd_build_t;

   typedef enum logic {
      OMD_PH_SETTLE,
      OMD_PH_RUN
   } omd_phase_t;

endpackage

`default_nettype wire

// >>> core/omd_sync.sv
// Two-stage synchroniser for the strap pins.
// Assumes the pins are quasi-static and may change at any time.
`default_nettype none

module omd_sync #(
   parameter int unsigned W = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // First stage is read only by the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule // omd_sync

`default_nettype wire

// >>> core/omd_mode_table.sv
// Combinational decode of a mode number into its attributes.
// Assumes the caller forces bit 3 low on builds without the flash enable pin.
`default_nettype none

module omd_mode_table #(
   parameter bit HAS_FWE = 1'b1,
   parameter omd_pkg::omd_build_t BUILD = omd_pkg::OMD_BUILD_FLASH
) (
   // Mode in
   input wire logic [3:0] mode_num,
   // Attributes out
   output logic supported,
   output logic rom_en,
   output logic fixed_exp,
   output logic init_w16,
   output logic boot,
   output logic user
);

   logic flash_build;
   logic romless_build;

   assign flash_build = (BUILD == omd_pkg::OMD_BUILD_FLASH);
   assign romless_build = (BUILD == omd_pkg::OMD_BUILD_ROMLESS);

   always_comb begin
      supported = 1'b0;
      case (mode_num)
         4'h1, 4'h2: supported = 1'b1;
         4'h3: supported = !HAS_FWE && flash_build;
         4'h4, 4'h5, 4'h6, 4'h7: supported = !romless_build;
         4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: supported = HAS_FWE && flash_build;
         default: supported = 1'b0;
      endcase
   end

   // Reserved codes get every attribute low, so flash stays locked
   always_comb begin
      rom_en = supported && (mode_num != 4'h1) && (mode_num != 4'h2);
      fixed_exp = supported && ((mode_num == 4'h1) || (mode_num == 4'h2) ||
                  (mode_num == 4'h4) || (mode_num == 4'h5) ||
                  (mode_num == 4'h6));
      init_w16 = supported && ((mode_num == 4'h1) || (mode_num == 4'h5) ||
                 (mode_num == 4'hD));
      boot = supported && ((mode_num == 4'h3) || (mode_num == 4'hA) ||
             (mode_num == 4'hB));
      user = supported && (mode_num >= 4'hC);
   end

endmodule // omd_mode_table

`default_nettype wire

// >>> core/omd_top.sv
// Operating-mode decoder: strap pins to mode, with an AXI4-Lite register port.
// Assumes strap pins are held steady while the device runs.
//
// What this block does
// - Mode comes only from the three select pins and the flash enable pin.
// - With flash enable pin, mode equals enable times eight plus select pins.
// - Modes 1,2 disable ROM; initial width 16 in 1,5,13, else 8.
// - Modes 1, 2 and 4 to 6 are externally expanded modes.
// - Expanded bus is 16 bits if any area is 16-bit, else 8.
// - Mode 7 starts single-chip; software may enable the external bus later.
// - Modes 3,10,11 boot, 12 to 15 user program; flash programmable there.
// - Without flash enable pin only modes 1 to 7 exist.
// - Accepted modes depend on a build parameter: flash, masked or ROM-less.
// - Monitor bits 2:0 show select pins 2:0, read-only.
// - Each monitor read latches pin levels; reset clears the latch.
// - Monitor bits 7:3 read zero and ignore writes.
`default_nettype none

module omd_top #(
   parameter bit HAS_FWE = 1'b1,
   parameter omd_pkg::omd_build_t BUILD = omd_pkg::OMD_BUILD_FLASH
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Strap pins
   input wire logic MODE_SELECT_PIN_2,
   input wire logic MODE_SELECT_PIN_1,
   input wire logic MODE_SELECT_PIN_0,
   input wire logic FLASH_WRITE_ENABLE_PIN,
   // Decoded mode
   output logic [3:0] MODE_NUMBER,
   output logic MODE_VALID,
   output logic MODE_CAPTURED,
   output logic ROM_ENABLE,
   output logic EXT_BUS_ENABLE,
   output logic BUS_WIDTH_16,
   output logic BOOT_MODE,
   output logic USER_PROGRAM_MODE,
   output logic FLASH_PROGRAM_ENABLE,
   // AXI4-Lite write address
   input wire logic [omd_pkg::ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   // AXI4-Lite write data
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // AXI4-Lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read address
   input wire logic [omd_pkg::ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   // AXI4-Lite read data
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      omd_pkg::omd_phase_t phase;
      logic [1:0] settle_cnt;
      logic [3:0] mode_num;
      logic valid;
      logic rom_en;
      logic fixed_exp;
      logic ext_sw;
      logic ext_en;
      logic bus16;
      logic boot;
      logic user;
      logic flash;
      logic [2:0] mon;
      logic [omd_pkg::AREA_COUNT-1:0] area16;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [omd_pkg::ADDR_W-1:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } omd_state_t;

   omd_state_t s_r;
   omd_state_t s_nxt;

   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   logic [3:0] pins_raw;
   logic [3:0] pins_sync;
   logic [3:0] cand_mode;

   assign pins_raw = {FLASH_WRITE_ENABLE_PIN, MODE_SELECT_PIN_2,
                      MODE_SELECT_PIN_1, MODE_SELECT_PIN_0};

   omd_sync #(
      .W(4)
   ) u_sync (
      .clk(CLK),
      .rst_n(RSTN),
      .d(pins_raw),
      .q(pins_sync)
   );

   // Flash enable carries weight eight only where the pin exists
   assign cand_mode = HAS_FWE ? pins_sync : {1'b0, pins_sync[2:0]};

   // ------------------------------------------------------------
   // Mode table
   // ------------------------------------------------------------
   logic t_sup;
   logic t_rom;
   logic t_fexp;
   logic t_w16;
   logic t_boot;
   logic t_user;

   omd_mode_table #(
      .HAS_FWE(HAS_FWE),
      .BUILD(BUILD)
   ) u_table (
      .mode_num(cand_mode),
      .supported(t_sup),
      .rom_en(t_rom),
      .fixed_exp(t_fexp),
      .init_w16(t_w16),
      .boot(t_boot),
      .user(t_user)
   );

   // ------------------------------------------------------------
   // Register read mux
   // ------------------------------------------------------------
   logic [31:0] status_word;
   logic [31:0] ctrl_word;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[omd_pkg::ST_MODE_LSB +: 4] = s_r.mode_num;
      status_word[omd_pkg::ST_VALID_BIT] = s_r.valid;
      status_word[omd_pkg::ST_ROM_BIT] = s_r.rom_en;
      status_word[omd_pkg::ST_EXT_BIT] = s_r.ext_en;
      status_word[omd_pkg::ST_BUS16_BIT] = s_r.bus16;
      status_word[omd_pkg::ST_BOOT_BIT] = s_r.boot;
      status_word[omd_pkg::ST_USER_BIT] = s_r.user;
      status_word[omd_pkg::ST_FLASH_BIT] = s_r.flash;
      status_word[omd_pkg::ST_CAPT_BIT] = (s_r.phase == omd_pkg::OMD_PH_RUN);
      ctrl_word = 32'h0000_0000;
      ctrl_word[omd_pkg::CTRL_EXT_BIT] = s_r.ext_en;
      ctrl_word[omd_pkg::CTRL_AREA_LSB +: omd_pkg::AREA_COUNT] = s_r.area16;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   logic wr_fire;
   logic rd_fire;

   assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
   assign rd_fire = ARVALID && s_r.arready;

   always_comb begin
      s_nxt = s_r;

      // Strap capture after the synchroniser has filled
      case (s_r.phase)
         omd_pkg::OMD_PH_SETTLE: begin
            if (s_r.settle_cnt == omd_pkg::CAPTURE_DELAY) begin
               s_nxt.phase = omd_pkg::OMD_PH_RUN;
               s_nxt.mode_num = cand_mode;
               s_nxt.valid = t_sup;
               s_nxt.rom_en = t_rom;
               s_nxt.fixed_exp = t_fexp;
               s_nxt.boot = t_boot;
               s_nxt.user = t_user;
               s_nxt.flash = t_boot || t_user;
               s_nxt.area16 = t_w16 ? omd_pkg::AREA_ALL_16 : omd_pkg::AREA_ALL_8;
            end else begin
               s_nxt.settle_cnt = s_r.settle_cnt + 2'h1;
            end
         end
         omd_pkg::OMD_PH_RUN: begin
            // Straps are not re-sampled; the board holds them steady
            s_nxt.phase = omd_pkg::OMD_PH_RUN;
         end
         default: begin
            s_nxt.phase = omd_pkg::OMD_PH_SETTLE;
         end
      endcase

      // Write channel acceptance, either order
      if (AWVALID && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = AWADDR;
      end
      if (WVALID && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = WDATA;
         s_nxt.w_strb = WSTRB;
      end

      // Register write
      if (wr_fire) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = omd_pkg::RESP_OKAY;
         case (s_r.aw_addr)
            omd_pkg::MON_OFFSET: begin
               // Monitor is read-only in every bit
               s_nxt.mon = s_r.mon;
            end
            omd_pkg::STATUS_OFFSET: begin
               s_nxt.bresp = omd_pkg::RESP_OKAY;
            end
            omd_pkg::CTRL_OFFSET: begin
               // Only modes without a fixed bus let software switch it
               if (s_r.w_strb[0] && s_r.valid && !s_r.fixed_exp) begin
                  s_nxt.ext_sw = s_r.w_data[omd_pkg::CTRL_EXT_BIT];
               end
               if (s_r.w_strb[1]) begin
                  s_nxt.area16 = s_r.w_data[omd_pkg::CTRL_AREA_LSB +: omd_pkg::AREA_COUNT];
               end
            end
            default: begin
               s_nxt.bresp = omd_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_r.bvalid && BREADY) begin
         s_nxt.bvalid = 1'b0;
      end

      // Register read
      if (rd_fire) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = omd_pkg::RESP_OKAY;
         case (ARADDR)
            omd_pkg::MON_OFFSET: begin
               // Pin levels are latched at the moment of the read
               s_nxt.mon = pins_sync[2:0];
               s_nxt.rdata = {29'h0000_0000, pins_sync[2:0]};
            end
            omd_pkg::STATUS_OFFSET: begin
               s_nxt.rdata = status_word;
            end
            omd_pkg::CTRL_OFFSET: begin
               s_nxt.rdata = ctrl_word;
            end
            default: begin
               s_nxt.rdata = 32'h0000_0000;
               s_nxt.rresp = omd_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_r.rvalid && RREADY) begin
         s_nxt.rvalid = 1'b0;
      end

      // Bus use follows mode and software switch
      s_nxt.ext_en = s_nxt.fixed_exp || (s_nxt.valid && s_nxt.ext_sw);
      // Any 16-bit area widens the whole bus
      s_nxt.bus16 = s_nxt.ext_en && (|s_nxt.area16);

      // One transaction per direction in flight
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
      s_nxt.arready = !s_nxt.rvalid;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         s_r <= '0;
         s_r.phase <= omd_pkg::OMD_PH_SETTLE;
         s_r.mode_num <= omd_pkg::MODE_RESET;
         s_r.mon <= omd_pkg::MON_RESET;
         s_r.area16 <= omd_pkg::AREA_ALL_8;
         s_r.bresp <= omd_pkg::RESP_OKAY;
         s_r.rresp <= omd_pkg::RESP_OKAY;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign MODE_NUMBER = s_r.mode_num;
   assign MODE_VALID = s_r.valid;
   assign MODE_CAPTURED = (s_r.phase == omd_pkg::OMD_PH_RUN);
   assign ROM_ENABLE = s_r.rom_en;
   assign EXT_BUS_ENABLE = s_r.ext_en;
   assign BUS_WIDTH_16 = s_r.bus16;
   assign BOOT_MODE = s_r.boot;
   assign USER_PROGRAM_MODE = s_r.user;
   assign FLASH_PROGRAM_ENABLE = s_r.flash;
   assign AWREADY = s_r.awready;
   assign WREADY = s_r.wready;
   assign BRESP = s_r.bresp;
   assign BVALID = s_r.bvalid;
   assign ARREADY = s_r.arready;
   assign RDATA = s_r.rdata;
   assign RRESP = s_r.rresp;
   assign RVALID = s_r.rvalid;

endmodule // omd_top

`default_nettype wire

// >>> bench/omd_props.sv
// Checker for the operating-mode decoder top level.
// Assumes it is bound to omd_top and sees only its ports.
`default_nettype none

module omd_props (
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // Decoded mode
   input wire logic [3:0] MODE_NUMBER,
   input wire logic MODE_VALID,
   input wire logic MODE_CAPTURED,
   input wire logic ROM_ENABLE,
   input wire logic EXT_BUS_ENABLE,
   input wire logic BUS_WIDTH_16,
   input wire logic BOOT_MODE,
   input wire logic USER_PROGRAM_MODE,
   input wire logic FLASH_PROGRAM_ENABLE,
   // Register bus
   input wire logic [omd_pkg::ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);

   // Remembers whether the read in flight targets the monitor
   logic mon_rd_r;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         mon_rd_r <= 1'b0;
      end else if (ARVALID && ARREADY) begin
         mon_rd_r <= (ARADDR == omd_pkg::MON_OFFSET);
      end
   end

   sequence s_release;
      $rose(RSTN);
   endsequence
   sequence s_capture;
      ##[1:6] MODE_CAPTURED;
   endsequence

   a_capture_soon: assert property (s_release |-> s_capture)
      else $error("straps not captured after reset");
   a_mode_held: assert property (MODE_CAPTURED [*3] |=> $stable(MODE_NUMBER))
      else $error("mode number moved after capture");
   a_rom_modes: assert property (
      MODE_VALID |-> ROM_ENABLE == !(MODE_NUMBER inside {4'h1, 4'h2}))
      else $error("rom enable wrong for mode");
   a_exp_fixed: assert property (
      MODE_VALID && (MODE_NUMBER inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6}) |-> EXT_BUS_ENABLE)
      else $error("expanded mode without bus");
   a_width_ext: assert property (BUS_WIDTH_16 |-> EXT_BUS_ENABLE)
      else $error("wide bus while bus off");
   a_boot_set: assert property (
      MODE_VALID |-> BOOT_MODE == (MODE_NUMBER inside {4'h3, 4'hA, 4'hB}))
      else $error("boot flag wrong for mode");
   a_user_set: assert property (
      MODE_VALID |-> USER_PROGRAM_MODE == (MODE_NUMBER >= 4'hC))
      else $error("user flag wrong for mode");
   a_flash_or: assert property (
      FLASH_PROGRAM_ENABLE == (BOOT_MODE || USER_PROGRAM_MODE))
      else $error("flash enable not boot or user");
   a_bad_no_flash: assert property (
      !MODE_VALID |-> !FLASH_PROGRAM_ENABLE && !BOOT_MODE && !USER_PROGRAM_MODE)
      else $error("reserved code enables flash");
   a_mon_upper: assert property (RVALID && mon_rd_r |-> RDATA[31:3] == 29'h0)
      else $error("monitor upper bits not zero");
   a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("no read answer");
   a_read_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped early");
   a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
      else $error("no write answer");
endmodule // omd_props

`default_nettype wire

// >>> bench/omd_straps.sv
// Board strap model for the operating-mode decoder.
// Assumes the bench only asks for a new code while reset is held.
`default_nettype none

module omd_straps (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Requested code, flash enable as bit 3
   input wire logic [3:0] code,
   // Strap pins
   output logic sel_2,
   output logic sel_1,
   output logic sel_0,
   output logic flash_write_enable_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins only move under reset, never while the part runs
   always @(posedge clk) begin
      if (!rst_n) begin
         {flash_write_enable_pin, sel_2, sel_1, sel_0} <= code;
      end
   end
endmodule // omd_straps

`default_nettype wire

// >>> bench/omd_top_tb.sv
// Self-checking bench for the operating-mode decoder, flash build with enable pin.
// Assumes omd_pkg, omd_top, omd_straps and omd_props are compiled first.
`default_nettype none

module omd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rstn;
   logic [3:0] code;
   logic p2, p1, p0, flash_write_enable_pin;
   logic [3:0] mode_num;
   logic valid, capt, rom, ext, b16, boot, user, flash;
   logic [omd_pkg::ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp;
   int error_cnt = 0;
   int checks = 0;

   always #12.5 clk = ~clk;

   omd_straps i_straps (.clk(clk), .rst_n(rstn), .code(code),
      .sel_2(p2), .sel_1(p1), .sel_0(p0), .flash_write_enable_pin(flash_write_enable_pin));

   omd_top i_dut (.CLK(clk), .RSTN(rstn),
      .MODE_SELECT_PIN_2(p2), .MODE_SELECT_PIN_1(p1), .MODE_SELECT_PIN_0(p0),
      .FLASH_WRITE_ENABLE_PIN(flash_write_enable_pin), .MODE_NUMBER(mode_num), .MODE_VALID(valid),
      .MODE_CAPTURED(capt), .ROM_ENABLE(rom), .EXT_BUS_ENABLE(ext), .BUS_WIDTH_16(b16),
      .BOOT_MODE(boot), .USER_PROGRAM_MODE(user), .FLASH_PROGRAM_ENABLE(flash),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
      .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

   // Masked-ROM variant without the flash enable pin, bus left idle
   logic [3:0] mode_m;
   logic valid_m;
   omd_top #(.HAS_FWE(1'b0), .BUILD(omd_pkg::OMD_BUILD_MASKED)) i_dut_mask (.CLK(clk),
      .RSTN(rstn), .MODE_SELECT_PIN_2(p2), .MODE_SELECT_PIN_1(p1), .MODE_SELECT_PIN_0(p0),
      .FLASH_WRITE_ENABLE_PIN(flash_write_enable_pin), .MODE_NUMBER(mode_m), .MODE_VALID(valid_m),
      .MODE_CAPTURED(), .ROM_ENABLE(), .EXT_BUS_ENABLE(), .BUS_WIDTH_16(), .BOOT_MODE(),
      .USER_PROGRAM_MODE(), .FLASH_PROGRAM_ENABLE(), .AWADDR(8'h00), .AWVALID(1'b0),
      .AWREADY(), .WDATA(32'h0), .WSTRB(4'h0), .WVALID(1'b0), .WREADY(), .BRESP(),
      .BVALID(), .BREADY(1'b0), .ARADDR(8'h00), .ARVALID(1'b0), .ARREADY(), .RDATA(),
      .RRESP(), .RVALID(), .RREADY(1'b0));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   // Ready rises with the request and holds until the answer is seen
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic strap_reset(input logic [3:0] c);
      @(posedge clk);
      rstn <= 1'b0;
      code <= c;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   // Expected {valid, rom, ext, bus16, boot, user, flash} for the flash build
   function automatic logic [6:0] exp_attr(input logic [3:0] c);
      logic s, e, bt, us;
      s = !(c inside {4'h0, 4'h3, 4'h8, 4'h9});
      e = s && (c inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h6});
      bt = s && (c inside {4'hA, 4'hB});
      us = s && (c >= 4'hC);
      return {s, s && !(c inside {4'h1, 4'h2}), e, e && (c inside {4'h1, 4'h5}), bt, us, bt || us};
   endfunction

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_modes;
      logic [31:0] d;
      logic [1:0] r;
      logic vm;
      for (int c = 0; c < 16; c++) begin
         strap_reset(c[3:0]);
         chk("mode_num", {28'h0, c[3:0]}, {28'h0, mode_num});
         chk("attrs", {25'h0, exp_attr(c[3:0])},
            {25'h0, valid, rom, ext, b16, boot, user, flash});
         chk("captured", 32'h1, {31'h0, capt});
         vm = c[2:0] inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
         chk("variant", {27'h0, vm, 1'b0, c[2:0]}, {27'h0, valid_m, mode_m});
         axr(omd_pkg::MON_OFFSET, d, r);
         chk("monitor", {29'h0, c[2:0]}, d);
      end
      $display("t_modes done");
   endtask

   task automatic t_soft_bus;
      logic [1:0] r;
      strap_reset(4'h7);
      chk("bus7_init", 32'h0, {30'h0, ext, b16});
      axw(omd_pkg::CTRL_OFFSET, 32'h1, r);
      repeat (3) @(posedge clk);
      chk("bus7_on", 32'h2, {30'h0, ext, b16});
      axw(omd_pkg::CTRL_OFFSET, 32'h101, r);
      repeat (3) @(posedge clk);
      chk("bus7_wide", 32'h3, {30'h0, ext, b16});
      strap_reset(4'h5);
      chk("bus5_init", 32'h3, {30'h0, ext, b16});
      axw(omd_pkg::CTRL_OFFSET, 32'h0, r);
      repeat (3) @(posedge clk);
      chk("bus5_off", 32'h2, {30'h0, ext, b16});
      $display("t_soft_bus done");
   endtask

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      axw(omd_pkg::MON_OFFSET, 32'hFFFFFFFF, r);
      chk("mon_wr_resp", {30'h0, omd_pkg::RESP_OKAY}, {30'h0, r});
      axr(omd_pkg::MON_OFFSET, d, r);
      chk("mon_ro", 32'h5, d);
      axr(omd_pkg::STATUS_OFFSET, d, r);
      chk("status", 32'h875, d);
      axr(8'h0C, d, r);
      chk("unm_rd_resp", {30'h0, omd_pkg::RESP_SLVERR}, {30'h0, r});
      chk("unm_rd_data", 32'h0, d);
      axw(8'h0C, 32'h1, r);
      chk("unm_wr_resp", {30'h0, omd_pkg::RESP_SLVERR}, {30'h0, r});
      $display("t_regs done");
   endtask

   // ------------------------------------------------------------
   // Sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      code = 4'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_modes();
      t_soft_bus();
      t_regs();
      end_sim();
   end

   // Run needs about 550 cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
endmodule // omd_top_tb

bind omd_top omd_props i_props (.CLK(CLK), .RSTN(RSTN),
   .MODE_NUMBER(MODE_NUMBER), .MODE_VALID(MODE_VALID), .MODE_CAPTURED(MODE_CAPTURED),
   .ROM_ENABLE(ROM_ENABLE), .EXT_BUS_ENABLE(EXT_BUS_ENABLE), .BUS_WIDTH_16(BUS_WIDTH_16),
   .BOOT_MODE(BOOT_MODE), .USER_PROGRAM_MODE(USER_PROGRAM_MODE),
   .FLASH_PROGRAM_ENABLE(FLASH_PROGRAM_ENABLE), .ARADDR(ARADDR), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .AWVALID(AWVALID),
   .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID));

`default_nettype wire
